// *** asa_consts.vh ***
`ifndef ASA_CONSTS_VH
`define ASA_CONSTS_VH
// ==========================================================
// Register select codes.
`define ASA_RS_DATA        2'h0
`define ASA_RS_RESET_STAT  2'h1
`define ASA_RS_COMMAND     2'h2
`define ASA_RS_CONTROL     2'h3
// ==========================================================
// Line format control fields.
`define ASA_CTL_BAUD_LSB   0
`define ASA_CTL_BAUD_MSB   3
`define ASA_CTL_RXSRC      4
`define ASA_CTL_WLEN_LSB   5
`define ASA_CTL_WLEN_MSB   6
`define ASA_CTL_STOP       7
`define ASA_CTL_RESET      8'h00
// ==========================================================
// Mode command fields.
`define ASA_CMD_ENABLE     0
`define ASA_CMD_RXIRQ_OFF  1
`define ASA_CMD_TXC_LSB    2
`define ASA_CMD_TXC_MSB    3
`define ASA_CMD_ECHO       4
`define ASA_CMD_PAR_EN     5
`define ASA_CMD_PAR_LSB    6
`define ASA_CMD_PAR_MSB    7
`define ASA_CMD_RESET      8'h00
`define ASA_CMD_SOFT_MASK  8'hE0
// ==========================================================
// Line status fields.
`define ASA_ST_PARITY      0
`define ASA_ST_FRAMING     1
`define ASA_ST_OVERRUN     2
`define ASA_ST_RXFULL      3
`define ASA_ST_TXEMPTY     4
`define ASA_ST_DCD         5
`define ASA_ST_DSR         6
`define ASA_ST_IRQ         7
// ==========================================================
// Timing.
`define ASA_XTAL_HZ        1843200
`define ASA_OVERSAMPLE     16
`define ASA_HALF_BIT       4'h7
`define ASA_FULL_BIT       4'hF
`define ASA_FIFO_DEPTH     8
`endif

// *** asa_fifo.v ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Small synchronous FIFO with valid/ready on both sides.
module asa_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset.
	input  wire             clk_sys,
	input  wire             rst,
	// Filling side.
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Draining side.
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data,
	// Synchronous flush.
	input  wire             flush
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage is written without reset; only pointers and count need a defined value.
	always @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointer and count update.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // asa_fifo
`default_nettype wire

// *** asa_modem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Modem model: sends frames on rxd, collects frames from txd.
module asa_modem_model (
	// Clock.
	input  wire logic clk_sys,
	// Serial and modem pins.
	input  wire logic txd,
	output var  logic rxd,
	output var  logic cts_n,
	output var  logic dsr_n,
	output var  logic carrier_detect_n
);
	int          bit_t = 2;
	int          nb    = 8;
	int          par   = 0;
	logic [10:0] f;
	logic [10:0] q [$];
	// Static levels from time zero; a floating input is never allowed.
	initial begin
		rxd = 1'b1;
		cts_n = 1'b0;
		dsr_n = 1'b0;
		carrier_detect_n = 1'b1;
	end
	// Frame bits after the start bit are sampled at mid-bit, LSB first.
	initial begin
		forever begin
			@(negedge txd);
			repeat (bit_t / 2) @(posedge clk_sys);
			f = '0;
			for (int i = 0; i < nb + par + 1; i++) begin
				repeat (bit_t) @(posedge clk_sys);
				f[i] = txd;
			end
			q.push_back(f);
		end
	end
	// Sends one start bit, then n bits of the frame, then idles high.
	task automatic send(input logic [10:0] bits, input int n);
		@(posedge clk_sys) #1 rxd = 1'b0;
		for (int i = 0; i <= n; i++) begin
			repeat (bit_t) @(posedge clk_sys);
			#1 rxd = (i == n) ? 1'b1 : bits[i];
		end
	endtask
endmodule // asa_modem_model
`default_nettype wire

// *** asa_top.v ***
// Function
// - Respond only when select_high high, select_low_n low.
// - Register selects pick data, reset/status, command, control.
// - Soft reset clears command 4:0, status bit2.
// - Command and control read/write, others one-way.
// - Hardware reset low clears internal registers.
// - Read/write high reads, low writes, phase-two timed.
// - Drive data bus only on selected reads.
// - Open-drain interrupt pulled low on condition.
// - Control bits 3:0 pick fifteen baud rates.
// - Receive clock pin outputs internal 16x clock.
// - Receiver rate: baud generator or external/16.
// - Transmit LSB first, ignore unused high bits.
// - Receive LSB in bit0, unused bits zero.
// - Five to eight bits, parity, stop bits.
// - Transmitter starts a character only while clear-to-send low.
// - Terminal-ready output follows command bit zero.
// - Request-to-send set only by command register.
// - Modem ready and carrier inputs active low.
// - Baud generator runs from crystal input edges.
`timescale 1ns/1ps
`default_nettype none
`include "asa_consts.vh"
module asa_top #(
	parameter FIFO_DEPTH = `ASA_FIFO_DEPTH
) (
	// System clock and reset.
	input  wire       clk_sys,
	input  wire       rst,
	// Processor bus pins.
	input  wire       phi2,
	input  wire       select_high,
	input  wire       select_low_n,
	input  wire       reg_sel_lo,
	input  wire       reg_sel_hi,
	input  wire       rw,
	input  wire       hw_reset_n,
	input  wire [7:0] data_in,
	output reg  [7:0] data_out,
	output wire       data_oe,
	output wire       irq_n_out,
	output wire       irq_n_oe,
	// Clock pins.
	input  wire       crystal_in,
	output wire       crystal_out,
	input  wire       rx_x16_clock_in,
	output reg        rx_x16_clock_out,
	output wire       rx_x16_clock_oe,
	// Serial and modem pins.
	output reg        txd,
	input  wire       rxd,
	output wire       rts_n,
	input  wire       cts_n,
	output wire       dtr_n,
	input  wire       dsr_n,
	input  wire       carrier_detect_n
);
	// ==========================================================
	// Pin synchronisers.
	localparam NPIN = 21;
	wire [NPIN-1:0] pin_raw;
	reg  [NPIN-1:0] pin_s1;
	reg  [NPIN-1:0] pin_s2;
	reg  [2:0]      edge_d;
	assign pin_raw = {data_in, rx_x16_clock_in, carrier_detect_n, dsr_n, cts_n, rxd,
		crystal_in, hw_reset_n, rw, reg_sel_hi, reg_sel_lo, select_low_n, select_high, phi2};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
			// Two stages per pin; only the second stage feeds logic.
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s2_next(pin_s1[gi]);
				end
			end
		end
	endgenerate
	function pin_s2_next;
		input v;
		pin_s2_next = v;
	endfunction

	wire       s_phi2  = pin_s2[0];
	wire       s_sel   = pin_s2[1] & ~pin_s2[2];
	wire [1:0] s_rs    = {pin_s2[4], pin_s2[3]};
	wire       s_rw    = pin_s2[5];
	wire       s_hwrst = ~pin_s2[6];
	wire       s_xtal  = pin_s2[7];
	wire       s_rxd   = pin_s2[8];
	wire       s_cts_n = pin_s2[9];
	wire       s_dsr_n = pin_s2[10];
	wire       s_dcd_n = pin_s2[11];
	wire       s_rxc   = pin_s2[12];
	wire [7:0] s_data  = pin_s2[20:13];

	// Previous samples for edge detection on phase two, crystal and receive clock.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			edge_d <= 3'h0;
		end else begin
			edge_d <= {s_rxc, s_xtal, s_phi2};
		end
	end
	wire phi2_fall = edge_d[0] & ~s_phi2;
	wire xtal_tick = s_xtal & ~edge_d[1];
	wire rxc_tick  = s_rxc & ~edge_d[2];
	wire bus_wr    = phi2_fall & s_sel & ~s_rw;
	wire bus_rd    = phi2_fall & s_sel & s_rw;
	assign crystal_out = ~s_xtal;

	// ==========================================================
	// Registers.
	reg  [7:0] ctl;
	reg  [7:0] cmd;
	reg  [7:0] rx_hold;
	reg        st_par;
	reg        st_frm;
	reg        st_ovr;
	reg        st_full;
	wire       rx_done;
	wire [7:0] rx_word;
	wire       rx_perr;
	wire       rx_ferr;
	wire       fifo_ready;
	wire       wr_data  = bus_wr & (s_rs == `ASA_RS_DATA);
	wire       wr_sreset = bus_wr & (s_rs == `ASA_RS_RESET_STAT);
	wire       rd_data  = bus_rd & (s_rs == `ASA_RS_DATA);
	wire [1:0] txc      = cmd[`ASA_CMD_TXC_MSB:`ASA_CMD_TXC_LSB];
	wire       tx_irq_en = (txc == 2'h1);
	wire       irq_act  = (st_full & ~cmd[`ASA_CMD_RXIRQ_OFF]) | (fifo_ready & tx_irq_en);

	// Control and command; hardware reset clears all, soft reset only command 4:0.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctl <= `ASA_CTL_RESET;
			cmd <= `ASA_CMD_RESET;
		end else if (s_hwrst) begin
			ctl <= `ASA_CTL_RESET;
			cmd <= `ASA_CMD_RESET;
		end else if (wr_sreset) begin
			cmd <= cmd & `ASA_CMD_SOFT_MASK;
		end else if (bus_wr & (s_rs == `ASA_RS_COMMAND)) begin
			cmd <= s_data;
		end else if (bus_wr & (s_rs == `ASA_RS_CONTROL)) begin
			ctl <= s_data;
		end
	end

	// Receive holding and flags; a new character beats a same-cycle read.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_hold <= 8'h00;
			st_par  <= 1'b0;
			st_frm  <= 1'b0;
			st_ovr  <= 1'b0;
			st_full <= 1'b0;
		end else if (s_hwrst) begin
			rx_hold <= 8'h00;
			st_par  <= 1'b0;
			st_frm  <= 1'b0;
			st_ovr  <= 1'b0;
			st_full <= 1'b0;
		end else begin
			if (rx_done & st_full & ~rd_data) begin
				st_ovr <= 1'b1;
			end else if (wr_sreset) begin
				st_ovr <= 1'b0;
			end
			if (rx_done & ~(st_full & ~rd_data)) begin
				rx_hold <= rx_word;
				st_par  <= rx_perr;
				st_frm  <= rx_ferr;
				st_full <= 1'b1;
			end else if (rd_data) begin
				st_full <= 1'b0;
			end
		end
	end

	// Read data mux, registered; the status byte shows the interrupt source.
	wire [7:0] status = {irq_act, s_dsr_n, s_dcd_n, fifo_ready, st_full,
		st_ovr, st_frm, st_par};
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			data_out <= 8'h00;
		end else begin
			case (s_rs)
				`ASA_RS_DATA:       data_out <= rx_hold;
				`ASA_RS_RESET_STAT: data_out <= status;
				`ASA_RS_COMMAND:    data_out <= cmd;
				`ASA_RS_CONTROL:    data_out <= ctl;
				default:            data_out <= 8'h00;
			endcase
		end
	end
	assign data_oe   = s_sel & s_rw;
	assign irq_n_out = 1'b0;
	assign irq_n_oe  = irq_act;
	assign dtr_n     = ~cmd[`ASA_CMD_ENABLE];
	assign rts_n     = (txc == 2'h0);

	// ==========================================================
	// Baud generator from crystal edges.
	reg  [11:0] div_cnt;
	reg  [11:0] divisor;
	wire [3:0]  baud_sel = ctl[`ASA_CTL_BAUD_MSB:`ASA_CTL_BAUD_LSB];
	// Divisor of the crystal for a 16x clock; code zero uses the crystal directly.
	always @* begin
		case (baud_sel)
			4'h1:    divisor = 12'h900;
			4'h2:    divisor = 12'h600;
			4'h3:    divisor = 12'h417;
			4'h4:    divisor = 12'h359;
			4'h5:    divisor = 12'h300;
			4'h6:    divisor = 12'h180;
			4'h7:    divisor = 12'h0C0;
			4'h8:    divisor = 12'h060;
			4'h9:    divisor = 12'h040;
			4'hA:    divisor = 12'h030;
			4'hB:    divisor = 12'h020;
			4'hC:    divisor = 12'h018;
			4'hD:    divisor = 12'h010;
			4'hE:    divisor = 12'h00C;
			4'hF:    divisor = 12'h006;
			default: divisor = 12'h001;
		endcase
	end
	wire div_wrap = xtal_tick & (div_cnt >= divisor - 12'h001);
	wire tx_tick  = div_wrap;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_cnt          <= 12'h000;
			rx_x16_clock_out <= 1'b0;
		end else begin
			if (div_wrap) begin
				div_cnt <= 12'h000;
			end else if (xtal_tick) begin
				div_cnt <= div_cnt + 12'h001;
			end
			rx_x16_clock_out <= (baud_sel == 4'h0) ? s_xtal : (div_cnt < {1'b0, divisor[11:1]});
		end
	end
	wire rx_int = ctl[`ASA_CTL_RXSRC];
	assign rx_x16_clock_oe = rx_int;
	wire rx_tick = rx_int ? tx_tick : rxc_tick;

	// ==========================================================
	// Character format: word length and parity for both directions, stop period for transmit only.
	wire [3:0] wlen   = 4'h8 - {2'h0, ctl[`ASA_CTL_WLEN_MSB:`ASA_CTL_WLEN_LSB]};
	wire [7:0] wmask  = 8'hFF >> (4'h8 - wlen);
	wire       par_en = cmd[`ASA_CMD_PAR_EN];
	wire [1:0] par_md = cmd[`ASA_CMD_PAR_MSB:`ASA_CMD_PAR_LSB];
	wire [3:0] nbits  = wlen + {3'h0, par_en};
	// Stop period in half bits: 2, 3 for five bits unparitied, else 4.
	wire [2:0] stop_h = ~ctl[`ASA_CTL_STOP] ? 3'h2 : ((wlen == 4'h5 && !par_en) ? 3'h3 : 3'h4);
	function par_of;
		input [7:0] d;
		input [1:0] md;
		case (md)
			2'h0:    par_of = ~^d;
			2'h1:    par_of = ^d;
			2'h2:    par_of = 1'b1;
			default: par_of = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// Transmitter.
	localparam TX_IDLE = 2'h0;
	localparam TX_BITS = 2'h1;
	localparam TX_STOP = 2'h2;
	reg  [1:0]  tx_st;
	reg  [10:0] tx_sr;
	reg  [3:0]  tx_left;
	reg  [3:0]  tx_ph;
	reg  [2:0]  tx_half;
	wire [7:0]  fifo_q;
	wire        fifo_valid;
	wire        tx_go  = (tx_st == TX_IDLE) & fifo_valid & ~s_cts_n & cmd[`ASA_CMD_ENABLE];
	wire [7:0]  tx_dat = fifo_q & wmask;
	wire [9:0]  tx_fr  = {2'h0, tx_dat} | ({9'h000, par_en & par_of(tx_dat, par_md)} << wlen);

	asa_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (3)
	) u_txq (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (wr_data),
		.in_ready  (fifo_ready),
		.in_data   (s_data),
		.out_valid (fifo_valid),
		.out_ready (tx_go),
		.out_data  (fifo_q),
		.flush     (s_hwrst)
	);

	// One character at a time; a busy line leaves further bytes queued.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_st   <= TX_IDLE;
			tx_sr   <= 11'h7FF;
			tx_left <= 4'h0;
			tx_ph   <= 4'h0;
			tx_half <= 3'h0;
		end else if (s_hwrst) begin
			tx_st <= TX_IDLE;
			tx_sr <= 11'h7FF;
		end else begin
			case (tx_st)
				TX_IDLE: begin
					if (tx_go) begin
						tx_sr   <= {tx_fr, 1'b0};
						tx_left <= nbits + 4'h1;
						tx_ph   <= 4'h0;
						tx_st   <= TX_BITS;
					end
				end
				TX_BITS: begin
					if (tx_tick) begin
						tx_ph <= tx_ph + 4'h1;
						if (tx_ph == `ASA_FULL_BIT) begin
							tx_sr   <= {1'b1, tx_sr[10:1]};
							tx_left <= tx_left - 4'h1;
							if (tx_left == 4'h1) begin
								tx_st   <= TX_STOP;
								tx_half <= stop_h;
							end
						end
					end
				end
				TX_STOP: begin
					if (tx_tick) begin
						tx_ph <= tx_ph + 4'h1;
						if (tx_ph[2:0] == 3'h7) begin
							tx_half <= tx_half - 3'h1;
							if (tx_half == 3'h1) begin
								tx_st <= TX_IDLE;
							end
						end
					end
				end
				default: tx_st <= TX_IDLE;
			endcase
		end
	end

	// Line driver: break, echo of the received line, or the shifter.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			txd <= 1'b1;
		end else if (txc == 2'h3) begin
			txd <= 1'b0;
		end else if (cmd[`ASA_CMD_ECHO] && txc == 2'h0) begin
			txd <= s_rxd;
		end else begin
			txd <= (tx_st == TX_BITS) ? tx_sr[0] : 1'b1;
		end
	end

	// ==========================================================
	// Receiver.
	localparam RX_IDLE  = 2'h0;
	localparam RX_START = 2'h1;
	localparam RX_BITS  = 2'h2;
	localparam RX_STOP  = 2'h3;
	reg  [1:0] rx_st;
	reg  [3:0] rx_ph;
	reg  [3:0] rx_n;
	reg  [8:0] rx_sr;
	reg        rx_fin;
	reg        rx_ferr_r;
	wire [8:0] rx_al  = rx_sr >> (4'h9 - nbits);
	assign rx_word = rx_al[7:0] & wmask;
	assign rx_perr = par_en & (rx_al[wlen] != par_of(rx_word, par_md));
	assign rx_ferr = rx_ferr_r;
	assign rx_done = rx_fin;

	// Mid-bit sampling at sixteen ticks per bit after a validated start.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_st     <= RX_IDLE;
			rx_ph     <= 4'h0;
			rx_n      <= 4'h0;
			rx_sr     <= 9'h000;
			rx_fin    <= 1'b0;
			rx_ferr_r <= 1'b0;
		end else if (s_hwrst) begin
			rx_st  <= RX_IDLE;
			rx_fin <= 1'b0;
		end else begin
			rx_fin <= 1'b0;
			case (rx_st)
				RX_IDLE: begin
					if (rx_tick && !s_rxd) begin
						rx_ph <= 4'h0;
						rx_st <= RX_START;
					end
				end
				RX_START: begin
					if (rx_tick) begin
						rx_ph <= rx_ph + 4'h1;
						if (rx_ph == `ASA_HALF_BIT) begin
							rx_ph <= 4'h0;
							rx_n  <= 4'h0;
							rx_st <= s_rxd ? RX_IDLE : RX_BITS;
						end
					end
				end
				RX_BITS: begin
					if (rx_tick) begin
						rx_ph <= rx_ph + 4'h1;
						if (rx_ph == `ASA_FULL_BIT) begin
							rx_sr <= {s_rxd, rx_sr[8:1]};
							rx_n  <= rx_n + 4'h1;
							if (rx_n + 4'h1 == nbits) begin
								rx_st <= RX_STOP;
							end
						end
					end
				end
				RX_STOP: begin
					if (rx_tick) begin
						rx_ph <= rx_ph + 4'h1;
						if (rx_ph == `ASA_FULL_BIT) begin
							rx_ferr_r <= ~s_rxd;
							rx_fin    <= 1'b1;
							rx_st     <= RX_IDLE;
						end
					end
				end
				default: rx_st <= RX_IDLE;
			endcase
		end
	end
endmodule // asa_top
`default_nettype wire

// *** asa_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checks for the serial adapter.
module asa_top_sva #(
	parameter FIFO_DEPTH = 8
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Bus pins.
	input wire logic select_high,
	input wire logic select_low_n,
	input wire logic rw,
	input wire logic hw_reset_n,
	input wire logic data_oe,
	input wire logic irq_n_out,
	input wire logic irq_n_oe,
	// Clock and modem pins.
	input wire logic crystal_in,
	input wire logic crystal_out,
	input wire logic rx_x16_clock_oe,
	input wire logic txd,
	input wire logic cts_n,
	input wire logic rts_n,
	input wire logic dtr_n
);
	// Longer than any high run in a frame at the rates used with clear-to-send high.
	localparam int IDLE_MAX = 2000;
	int idle_cnt;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Counts idle-line cycles under clear-to-send high, saturating.
	always @(posedge clk_sys or posedge rst) begin
		if (rst)
			idle_cnt <= 0;
		else if (!cts_n || !txd)
			idle_cnt <= 0;
		else if (idle_cnt < IDLE_MAX)
			idle_cnt <= idle_cnt + 1;
	end
	// A quiet bus: deselected, with the pin reset released.
	sequence bus_quiet;
		(!select_high && hw_reset_n) [*6];
	endsequence
	// The pin reset held long enough to pass its synchroniser.
	sequence pin_reset;
		(!hw_reset_n) [*5];
	endsequence
	// Drive enable mirrors a selected read seen through the two-flop synchroniser.
	property rd_enable;
		data_oe == ($past(select_high, 2) && !$past(select_low_n, 2) && $past(rw, 2));
	endproperty
	// ==========================================================
	// Assertions.
	oe_follows_a: assert property (rd_enable) else $error("Bus drive enable wrong.");
	irq_drain_a: assert property (irq_n_out == 1'b0) else $error("IRQ drives high.");
	modem_hold_a: assert property (bus_quiet |-> $stable(dtr_n) && $stable(rts_n))
		else $error("Modem outputs moved without a write.");
	rxclk_hold_a: assert property (bus_quiet |-> $stable(rx_x16_clock_oe))
		else $error("Receive clock direction moved without a write.");
	hw_clear_a: assert property (pin_reset |-> dtr_n && rts_n && !irq_n_oe && txd)
		else $error("Pin reset did not clear outputs.");
	xtal_high_a: assert property (crystal_in [*3] |-> !crystal_out)
		else $error("Crystal output not inverted.");
	xtal_low_a: assert property (!crystal_in [*3] |-> crystal_out)
		else $error("Crystal output not inverted.");
	cts_hold_a: assert property (idle_cnt == IDLE_MAX |-> txd)
		else $error("Frame started while clear-to-send high.");
endmodule // asa_top_sva

bind asa_top asa_top_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_sva (
	.clk_sys, .rst, .select_high, .select_low_n, .rw, .hw_reset_n, .data_oe, .irq_n_out,
	.irq_n_oe, .crystal_in, .crystal_out, .rx_x16_clock_oe, .txd, .cts_n, .rts_n, .dtr_n
);
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the serial adapter.
module tb;
	logic        clk_sys, rst, phi2, select_high, select_low_n, reg_sel_lo, reg_sel_hi;
	logic        rw, hw_reset_n, crystal_in, ext_ck, pe;
	logic [7:0]  bus_d, rv, v, w;
	logic [7:0]  exp_q [9];
	logic [31:0] seed;
	int          errors, comparisons, n;
	wire  [7:0]  data_in, data_out;
	wire         data_oe, irq_n_out, irq_n_oe, crystal_out, rx_x16_clock_in, rx_x16_clock_out;
	wire         rx_x16_clock_oe, txd, rxd, rts_n, cts_n, dtr_n, dsr_n, carrier_detect_n, irq_line;
	// Two-way pins resolved from the enables; the IRQ line has a pull-up.
	assign data_in = data_oe ? data_out : bus_d;
	assign rx_x16_clock_in = rx_x16_clock_oe ? rx_x16_clock_out : ext_ck;
	assign irq_line = irq_n_oe ? irq_n_out : 1'b1;
	asa_top #(.FIFO_DEPTH(8)) i_dut (
		.clk_sys, .rst, .phi2, .select_high, .select_low_n, .reg_sel_lo, .reg_sel_hi,
		.rw, .hw_reset_n, .data_in, .data_out, .data_oe, .irq_n_out, .irq_n_oe,
		.crystal_in, .crystal_out, .rx_x16_clock_in, .rx_x16_clock_out, .rx_x16_clock_oe,
		.txd, .rxd, .rts_n, .cts_n, .dtr_n, .dsr_n, .carrier_detect_n
	);
	asa_modem_model i_modem (.clk_sys, .txd, .rxd, .cts_n, .dsr_n, .carrier_detect_n);
	// System clock, plus a fast reference (6 cycles) and external 16x clock (4 cycles).
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		crystal_in = 1'b0;
		@(negedge rst);
		forever #24 crystal_in = ~crystal_in;
	end
	initial begin
		ext_ck = 1'b0;
		forever #16 ext_ck = ~ext_ck;
	end
	// Compares and counts.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("Counts: %0d comparisons, %0d errors", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// One transfer: pins settle with phi2 high, the transfer is taken on its fall.
	task automatic bus(input logic [1:0] rs, input logic r, input logic [7:0] d);
		@(posedge clk_sys) #1;
		{reg_sel_hi, reg_sel_lo} = rs;
		rw = r;
		bus_d = d;
		select_high = 1'b1;
		select_low_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		#1 rv = data_out;
		phi2 = 1'b0;
		repeat (6) @(posedge clk_sys);
		#1 {select_high, select_low_n, phi2} = 3'b011;
	endtask
	task automatic wr(input logic [1:0] rs, input logic [7:0] d);
		bus(rs, 1'b0, d);
	endtask
	task automatic rd(input logic [1:0] rs);
		bus(rs, 1'b1, ~bus_d);
	endtask
	task automatic wait_q(input int k);
		for (int c = 0; c < 20000 && i_modem.q.size() < k; c++) @(posedge clk_sys);
		check(i_modem.q.size(), k);
	endtask
	// Frame after the start bit: data, parity if enabled, one stop bit.
	function automatic logic [10:0] frame(input logic [7:0] d, input int k, input logic e,
		input logic [1:0] pm);
		logic [7:0] m;
		logic       p;
		m = d & (8'hFF >> (8 - k));
		p = pm[1] ? ~pm[0] : (^m ^ ~pm[0]);
		frame = 11'(m) | (11'(p & e) << k) | (11'h001 << (k + e));
	endfunction
	// Cuts a hang short; the tests need well under this span.
	initial begin
		#700000;
		errors++;
		final_report;
	end
	initial begin
		seed = 32'hECDF18F2;
		{rst, phi2, select_high, select_low_n, reg_sel_hi, reg_sel_lo, rw, hw_reset_n} = 8'hD3;
		bus_d = 8'h00;
		repeat (16) @(posedge clk_sys);
		#1 rst = 1'b0;
		repeat (6) @(posedge clk_sys);
		rd(2'h2); check(rv, 8'h00);
		rd(2'h1); check(rv, 8'h30);
		$display("Test reset state done");
		// Every transmitter control code, random other bits.
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			v[3:2] = i[1:0];
			wr(2'h2, v);
			wr(2'h3, ~v);
			rd(2'h2); check(rv, v);
			rd(2'h3); check(rv, {~v});
			check(dtr_n, {~v[0]});
			check(rts_n, v[3:2] == 2'b00);
			// Break holds the line low; otherwise it idles high with an empty queue.
			check(txd, {v[3:2] != 2'b11});
			// Transmit interrupt mode with room in the queue pulls the shared line low.
			check(irq_line, {v[3:2] != 2'b01});
		end
		wr(2'h1, 8'($random(seed)));
		rd(2'h2); check(rv, v & 8'hE0);
		rd(2'h3); check(rv, {~v});
		check(dtr_n, 1'b1);
		@(posedge clk_sys) #1 hw_reset_n = 1'b0;
		repeat (8) @(posedge clk_sys);
		#1 hw_reset_n = 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(2'h3); check(rv, 8'h00);
		$display("Test registers done");
		// Each word length, parity off at eight bits and parity modes 1 to 3 below, both directions at once.
		for (int i = 0; i < 4; i++) begin
			n = 8 - i;
			pe = (i != 0);
			i_modem.nb = n;
			i_modem.par = pe;
			i_modem.bit_t = 96;
			wr(2'h3, {i[0], i[1:0], 1'b1, 4'h0});
			wr(2'h2, {i[1:0], pe, 1'b0, 2'b10, 1'b1, 1'b1});
			check(rx_x16_clock_oe, 1'b1);
			i_modem.q.delete();
			v = 8'($random(seed));
			w = 8'($random(seed));
			wr(2'h0, v);
			i_modem.send(frame(w, n, pe, i[1:0]), n + pe + 1);
			wait_q(1);
			check(i_modem.q.pop_front(), frame(v, n, pe, i[1:0]));
			rd(2'h1); check(rv[3:0], 4'h8);
			rd(2'h0); check(rv, w & (8'hFF >> (8 - n)));
		end
		$display("Test formats done");
		// Bad parity, then a second character lands before the first is read.
		wr(2'h2, 8'h69);
		i_modem.send(frame(w, 5, 1'b1, 2'b01) ^ 11'h020, 7);
		check(irq_line, 1'b0);
		rd(2'h1); check(rv & 8'h89, 8'h89);
		i_modem.send(frame(~w, 5, 1'b1, 2'b01), 7);
		rd(2'h1); check(rv & 8'h8C, 8'h8C);
		wr(2'h1, 8'h00);
		rd(2'h1); check(rv[2], 1'b0);
		rd(2'h0); check(rv, w & 8'h1F);
		check(irq_line, 1'b1);
		$display("Test errors done");
		// External receive clock at a different rate.
		wr(2'h2, 8'h0B);
		wr(2'h3, 8'h00);
		check(rx_x16_clock_oe, 1'b0);
		i_modem.nb = 8;
		i_modem.par = 0;
		i_modem.bit_t = 64;
		w = 8'($random(seed));
		i_modem.send(frame(w, 8, 1'b0, 2'b00), 9);
		rd(2'h0); check(rv, w);
		$display("Test external clock done");
		// Clear-to-send high: FIFO fills and refuses the ninth, line stays idle.
		wr(2'h3, 8'h10);
		i_modem.bit_t = 96;
		i_modem.q.delete();
		@(posedge clk_sys) #1 i_modem.cts_n = 1'b1;
		for (int i = 0; i < 9; i++) begin
			exp_q[i] = 8'($random(seed));
			wr(2'h0, exp_q[i]);
		end
		rd(2'h1); check(rv[4], 1'b0);
		repeat (2100) @(posedge clk_sys);
		check(i_modem.q.size(), 0);
		#1 i_modem.cts_n = 1'b0;
		wait_q(8);
		for (int i = 0; i < 8; i++) check(i_modem.q.pop_front(), frame(exp_q[i], 8, 1'b0, 2'b00));
		repeat (1200) @(posedge clk_sys);
		check(i_modem.q.size(), 0);
		rd(2'h1); check(rv[4], 1'b1);
		$display("Test flow control done");
		// Fastest divisor on the fast reference gives 576 cycles a bit.
		wr(2'h3, 8'h1F);
		i_modem.bit_t = 576;
		wr(2'h0, 8'hA5);
		wait_q(1);
		check(i_modem.q.pop_front(), frame(8'hA5, 8, 1'b0, 2'b00));
		// The 16x output repeats every 6 crystal ticks of 6 cycles: 10 rises in 360 cycles.
		@(posedge clk_sys) #1 w[0] = rx_x16_clock_out;
		n = 0;
		repeat (360) begin
			@(posedge clk_sys) #1;
			if (rx_x16_clock_out && !w[0]) n++;
			w[0] = rx_x16_clock_out;
		end
		check(n, 10);
		$display("Test divisor done");
		final_report;
	end
endmodule // tb
`default_nettype wire
